// File: hw/fnsc_serial_config.sv
`timescale 1ns/1ps
`default_nettype none
module fnsc_serial_config
(
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_serial_clk,
  input  wire logic                          i_serial_data,
  input  wire logic                          i_latch_load_strobe,
  input  wire logic                          i_lock_detect,
  input  wire logic                          i_scaled_feedback,
  input  wire logic                          i_scaled_reference,
  output logic                               o_test_mux_output,
  output logic                               o_fast_settle_bit,
  output logic [fnsc_pkg::INT_W-1:0]         o_int_value,
  output logic [fnsc_pkg::FRAC_W-1:0]        o_frac_value,
  output logic [fnsc_pkg::MOD_W-1:0]         o_fraction_modulus,
  output logic [fnsc_pkg::RCNT_W-1:0]        o_ref_count,
  output logic                               o_ref_doubler,
  output logic [fnsc_pkg::CTRL_W-1:0]        o_loop_control_word,
  output logic [fnsc_pkg::NOISE_W-1:0]       o_noise_spur_word,
  output logic                               o_reference_path_switch_a,
  output logic                               o_reference_path_switch_b,
  output logic                               o_reference_shunt_switch
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] clk_s_q;
  logic [1:0] dat_s_q;
  logic [1:0] le_s_q;
  logic       clk_old_q;
  logic       le_old_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      clk_s_q   <= 2'h0;
      dat_s_q   <= 2'h0;
      le_s_q    <= 2'h0;
      clk_old_q <= 1'b0;
      le_old_q  <= 1'b0;
    end
    else
    begin
      clk_s_q   <= {clk_s_q[0], i_serial_clk};
      dat_s_q   <= {dat_s_q[0], i_serial_data};
      le_s_q    <= {le_s_q[0], i_latch_load_strobe};
      clk_old_q <= clk_s_q[1];
      le_old_q  <= le_s_q[1];
    end
  end

  logic clk_rise;
  logic le_rise;
  assign clk_rise = clk_s_q[1] & ~clk_old_q;
  assign le_rise  = le_s_q[1] & ~le_old_q;

  // ****************************************************************
  // input shift register
  // ****************************************************************
  logic [fnsc_pkg::WORD_W-1:0] shift_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      shift_q <= '0;
    else if (clk_rise)
      shift_q <= {shift_q[fnsc_pkg::WORD_W-2:0], dat_s_q[1]};
  end

  // ****************************************************************
  // latches
  // ****************************************************************
  logic [1:0]                  sel;
  logic [fnsc_pkg::MOD_W-1:0]  mod_pend_q;
  logic [fnsc_pkg::MUX_W-1:0]  mux_sel_q;
  assign sel = shift_q[1:0];

  // reserved positions are never copied out, so host values there are moot
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_fast_settle_bit   <= 1'b0;
      o_int_value         <= '0;
      o_frac_value        <= '0;
      o_fraction_modulus  <= '0;
      mod_pend_q          <= '0;
      o_ref_count         <= '0;
      mux_sel_q           <= '0;
      o_loop_control_word <= '0;
      o_ref_doubler       <= 1'b0;
      o_noise_spur_word   <= '0;
    end
    else if (le_rise)
    begin
      unique case (sel)
        fnsc_pkg::SEL_DIV:
        begin
          o_fast_settle_bit  <= shift_q[fnsc_pkg::FAST_BIT];
          o_int_value        <= shift_q[fnsc_pkg::INT_LSB +: fnsc_pkg::INT_W];
          o_frac_value       <= shift_q[fnsc_pkg::FRAC_LSB +: fnsc_pkg::FRAC_W];
          o_fraction_modulus <= mod_pend_q;
        end
        fnsc_pkg::SEL_REFMOD:
        begin
          mod_pend_q  <= shift_q[fnsc_pkg::MOD_LSB +: fnsc_pkg::MOD_W];
          o_ref_count <= shift_q[fnsc_pkg::RCNT_LSB +: fnsc_pkg::RCNT_W];
          mux_sel_q   <= shift_q[fnsc_pkg::MUX_LSB +: fnsc_pkg::MUX_W];
        end
        fnsc_pkg::SEL_CTRL:
        begin
          o_loop_control_word <= shift_q[fnsc_pkg::CTRL_W-1:0];
          o_ref_doubler       <= shift_q[fnsc_pkg::DBL_BIT];
        end
        fnsc_pkg::SEL_NOISE:
          o_noise_spur_word <= shift_q[fnsc_pkg::NOISE_W-1:0];
      endcase
    end
  end

  // ****************************************************************
  // reference switches and test mux
  // ****************************************************************
  // mux sources are async analog-side levels, so they are resynchronised
  logic [2:0] src_s1_q;
  logic [2:0] src_s2_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      src_s1_q                  <= 3'h0;
      src_s2_q                  <= 3'h0;
      o_test_mux_output         <= 1'b0;
      o_reference_path_switch_a <= 1'b1;
      o_reference_path_switch_b <= 1'b1;
      o_reference_shunt_switch  <= 1'b0;
    end
    else
    begin
      src_s1_q <= {i_scaled_reference, i_scaled_feedback, i_lock_detect};
      src_s2_q <= src_s1_q;
      o_reference_path_switch_a <= ~o_loop_control_word[fnsc_pkg::PD_BIT];
      o_reference_path_switch_b <= ~o_loop_control_word[fnsc_pkg::PD_BIT];
      o_reference_shunt_switch  <= o_loop_control_word[fnsc_pkg::PD_BIT];
      if (mux_sel_q == fnsc_pkg::MUX_LOCK)
        o_test_mux_output <= src_s2_q[0];
      else if (mux_sel_q == fnsc_pkg::MUX_SCL_N)
        o_test_mux_output <= src_s2_q[1];
      else if (mux_sel_q == fnsc_pkg::MUX_SCL_R)
        o_test_mux_output <= src_s2_q[2];
      else
        o_test_mux_output <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_load_div;
    le_rise && sel == fnsc_pkg::SEL_DIV;
  endsequence

  chk_shift_in: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    clk_rise |=> shift_q[0] == $past(dat_s_q[1]))
    else $error("shift register missed a bit");

  chk_shift_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !clk_rise |=> $stable(shift_q))
    else $error("shift register moved without serial clock");

  chk_mod_apply: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_load_div |=> o_fraction_modulus == $past(mod_pend_q))
    else $error("modulus not applied on divider load");

  chk_mod_buffered: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (le_rise && sel == fnsc_pkg::SEL_REFMOD) |=> $stable(o_fraction_modulus))
    else $error("modulus changed without divider load");

  chk_int_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_load_div |=> o_int_value == $past(shift_q[fnsc_pkg::INT_LSB +: fnsc_pkg::INT_W]))
    else $error("integer value not loaded");

  chk_latch_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !le_rise |=> $stable(o_int_value) && $stable(o_loop_control_word) && $stable(mux_sel_q))
    else $error("latch changed without load strobe");

  chk_ctrl_sel: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (le_rise && sel == fnsc_pkg::SEL_CTRL) |=> $stable(o_int_value) && $stable(mod_pend_q))
    else $error("control load touched another latch");

  chk_pd_switch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_loop_control_word[fnsc_pkg::PD_BIT] [*2] |-> o_reference_shunt_switch
      && !o_reference_path_switch_a && !o_reference_path_switch_b)
    else $error("reference path not isolated in power-down");

  chk_mux_lock: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (mux_sel_q == fnsc_pkg::MUX_LOCK) [*2] |-> o_test_mux_output == $past(src_s2_q[0]))
    else $error("test mux not showing lock detect");

  sequence s_load_refmod;
    le_rise && sel == fnsc_pkg::SEL_REFMOD;
  endsequence

  chk_ref_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_load_refmod |=> o_ref_count == $past(shift_q[fnsc_pkg::RCNT_LSB +: fnsc_pkg::RCNT_W]))
    else $error("reference count not loaded");

  chk_frac_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_load_div |=> o_frac_value == $past(shift_q[fnsc_pkg::FRAC_LSB +: fnsc_pkg::FRAC_W]))
    else $error("fraction value not loaded");

  chk_noise_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (le_rise && sel == fnsc_pkg::SEL_NOISE)
      |=> o_noise_spur_word == $past(shift_q[fnsc_pkg::NOISE_W-1:0]))
    else $error("noise word not loaded");

  chk_pd_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!o_loop_control_word[fnsc_pkg::PD_BIT]) [*2] |-> !o_reference_shunt_switch
      && o_reference_path_switch_a && o_reference_path_switch_b)
    else $error("reference path not restored after power-up");

  chk_mux_feedback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (mux_sel_q == fnsc_pkg::MUX_SCL_N) [*2] |-> o_test_mux_output == $past(src_s2_q[1]))
    else $error("test mux not showing scaled feedback");

  chk_mux_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (mux_sel_q == '0) [*2] |-> !o_test_mux_output)
    else $error("test mux not quiet with no source chosen");

endmodule // fnsc_serial_config
`default_nettype wire

// File: hw/fnsc_pkg.sv
// What this block does
// - shift one data bit per serial clock rise
// - words arrive most significant bit first
// - load strobe rise copies word into one latch
// - latch chosen by shift bits one and zero
// - 00 divider, 01 ref/mod, 10 control, 11 noise
// - modulus applies only after next divider write
// - divide by int plus frac over modulus
// - counters: 4-bit ref, 9-bit int, 12-bit frac/mod
// - power-down opens reference path, closes shunt
// - test mux source from bits 22..20
// - mux offers lock, scaled feedback, scaled reference
`default_nettype none
package fnsc_pkg;
  localparam int          WORD_W     = 24;
  localparam logic [1:0]  SEL_DIV    = 2'h0;
  localparam logic [1:0]  SEL_REFMOD = 2'h1;
  localparam logic [1:0]  SEL_CTRL   = 2'h2;
  localparam logic [1:0]  SEL_NOISE  = 2'h3;
  // divider word fields
  localparam int          FAST_BIT   = 23;
  localparam int          INT_LSB    = 14;
  localparam int          INT_W      = 9;
  localparam int          FRAC_LSB   = 2;
  localparam int          FRAC_W     = 12;
  // reference and modulus word fields
  localparam int          MUX_LSB    = 20;
  localparam int          MUX_W      = 3;
  localparam int          RCNT_LSB   = 14;
  localparam int          RCNT_W     = 4;
  localparam int          MOD_LSB    = 2;
  localparam int          MOD_W      = 12;
  // control and noise word fields
  localparam int          CTRL_W     = 16;
  localparam int          DBL_BIT    = 11;
  localparam int          PD_BIT     = 5;
  localparam int          NOISE_W    = 11;
  // test mux encodings
  localparam logic [2:0]  MUX_LOCK   = 3'h1;
  localparam logic [2:0]  MUX_SCL_N  = 3'h2;
  localparam logic [2:0]  MUX_SCL_R  = 3'h3;
endpackage
`default_nettype wire

// File: verification/fnsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// host side of the three-wire link
// ****************
module fnsc_host_model
(
  output logic o_serial_clk,
  output logic o_serial_data,
  output logic o_latch_load_strobe
);
  initial
  begin
    o_serial_clk        <= 1'b0;
    o_serial_data       <= 1'b0;
    o_latch_load_strobe <= 1'b0;
  end
  // clock stands still between words; released data shows the inverse of its last bit
  task automatic send(input logic [23:0] word, input logic load);
    for (int i = 23; i >= 0; i--)
    begin
      o_serial_data <= word[i];
      #24 o_serial_clk <= 1'b1;
      #24 o_serial_clk <= 1'b0;
    end
    o_serial_data <= ~o_serial_data;
    if (load)
    begin
      #24 o_latch_load_strobe <= 1'b1;
      #48 o_latch_load_strobe <= 1'b0;
    end
    #48;
  endtask
endmodule // fnsc_host_model
`default_nettype wire

// File: verification/fnsc_serial_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fnsc_serial_config_tb;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n, i_serial_clk, i_serial_data, i_latch_load_strobe;
  logic        i_lock_detect, i_scaled_feedback, i_scaled_reference;
  logic        o_test_mux_output, o_fast_settle_bit, o_ref_doubler;
  logic        o_reference_path_switch_a, o_reference_path_switch_b, o_reference_shunt_switch;
  logic [8:0]  o_int_value;
  logic [11:0] o_frac_value, o_fraction_modulus;
  logic [3:0]  o_ref_count;
  logic [15:0] o_loop_control_word;
  logic [10:0] o_noise_spur_word;
  int          bad_count = 0;
  int          samples_checked = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  fnsc_serial_config fnsc_serial_config_i (.i_sys_clk, .i_rst_n, .i_serial_clk, .i_serial_data,
    .i_latch_load_strobe, .i_lock_detect, .i_scaled_feedback, .i_scaled_reference,
    .o_test_mux_output, .o_fast_settle_bit, .o_int_value, .o_frac_value, .o_fraction_modulus,
    .o_ref_count, .o_ref_doubler, .o_loop_control_word, .o_noise_spur_word,
    .o_reference_path_switch_a, .o_reference_path_switch_b, .o_reference_shunt_switch);
  fnsc_host_model fnsc_host_model_i (.o_serial_clk(i_serial_clk), .o_serial_data(i_serial_data),
    .o_latch_load_strobe(i_latch_load_strobe));
  // ****************
  // shared tasks
  // ****************
  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic put(input logic [23:0] w, input logic load);
    fnsc_host_model_i.send(w, load);
    repeat (10) @(posedge i_sys_clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    check(o_int_value, 24'h00_0000, "int");
    check({o_reference_path_switch_a, o_reference_path_switch_b, o_reference_shunt_switch},
          24'h00_0006, "switches");
  endtask
  task automatic t_divider;
    put(24'h03_FFFD, 1'b1);
    check(o_ref_count, 24'h00_000F, "rcount");
    check(o_fraction_modulus, 24'h00_0000, "mod pending");
    put(24'hFF_EAF0, 1'b1);
    check({o_fast_settle_bit, o_int_value, o_frac_value}, 24'h3F_FABC, "div fields");
    check(o_fraction_modulus, 24'h00_0FFF, "mod applied");
    put(24'h00_4009, 1'b1);
    check(o_fraction_modulus, 24'h00_0FFF, "mod held");
    put(24'h07_C004, 1'b0);
    check(o_int_value, 24'h00_01FF, "no strobe");
    put(24'h07_C004, 1'b1);
    check({o_fast_settle_bit, o_int_value, o_frac_value}, 24'h01_F001, "div low");
    check({o_ref_count, o_fraction_modulus}, 24'h00_1002, "mod two");
  endtask
  task automatic t_control;
    put(24'h00_0822, 1'b1);
    check({o_ref_doubler, o_loop_control_word}, 24'h01_0822, "ctrl");
    check({o_reference_path_switch_a, o_reference_path_switch_b, o_reference_shunt_switch},
          24'h00_0001, "powered down");
    put(24'h00_0802, 1'b1);
    check({o_reference_path_switch_a, o_reference_path_switch_b, o_reference_shunt_switch},
          24'h00_0006, "powered up");
    put(24'h00_03C7, 1'b1);
    check(o_loop_control_word, 24'h00_0802, "ctrl kept");
    check(o_noise_spur_word, 24'h00_03C7, "noise");
  endtask
  task automatic t_mux;
    logic exp;
    for (int s = 0; s < 8; s++)
    begin
      put(24'h00_4009 | (24'(s) << 20), 1'b1);
      for (int p = 0; p < 8; p++)
      begin
        @(posedge i_sys_clk);
        {i_lock_detect, i_scaled_feedback, i_scaled_reference} <= 3'(p);
        repeat (6) @(posedge i_sys_clk);
        exp = (s == 1) ? p[2] : (s == 2) ? p[1] : (s == 3) ? p[0] : 1'b0;
        check(o_test_mux_output, 24'(exp), "mux");
      end
    end
  endtask
  initial
  begin
    i_rst_n = 1'b0;
    {i_lock_detect, i_scaled_feedback, i_scaled_reference} = 3'h0;
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    t_reset();
    t_divider();
    t_control();
    t_mux();
    finish_test();
  end
  initial
  begin
    #200000;
    bad_count++;
    finish_test();
  end
endmodule // fnsc_serial_config_tb
`default_nettype wire
